/* File: src/mcw_defines.vh */
/*
 * Register offsets, field positions, reset values and timing counts for the
 * MCU miscellaneous control and watchdog block.
 * Assumes a 40 MHz core clock and an 8-bit register port.
 */
// Notes on behaviour
// - Config bit 5 enables hub overcurrent detection; resets to 0.
// - Config bit 6 low: interrupt line B follows port 3 bit 3.
// - Config bit 6 high: interrupt line B is OR of port 2 inputs.
// - Four 8-bit read/write pull-up registers, one per port 0 to 3.
// - Delay register low nibble sets port 2 delay in ms, resets 0010.
// - Watchdog counts 1 ms ticks in a 5-bit counter.
// - Watchdog does not count before a start-of-frame is seen.
// - 32 ms without a control register access resets the MCU.
// - Firmware kicks within 31 ms; writing 0 no effect; reads 0. Here any read or write of the register restarts the count.
// - Watchdog holds count while idle request is set.
// - Enable bit cleared only by power-up or USB reset.
// - Writing 1 to the enable bit starts the watchdog.
// - Reset cause flag is 0 after reset, set by watchdog timeout.
// - Writing 1 clears reset cause flag; writing 0 leaves it.
`ifndef MCW_DEFINES_VH
`define MCW_DEFINES_VH

`define MCW_ADDR_W            4
`define MCW_OFS_CONFIG        4'h0
`define MCW_OFS_PULLUP0       4'h1
`define MCW_OFS_PULLUP1       4'h2
`define MCW_OFS_PULLUP2       4'h3
`define MCW_OFS_PULLUP3       4'h4
`define MCW_OFS_IRQ_DELAY     4'h5
`define MCW_OFS_DOG           4'h6
`define MCW_OFS_IRQ_STATUS    4'h7
`define MCW_OFS_IRQ_MASK      4'h8

`define MCW_CFG_OVC_BIT       5
`define MCW_CFG_XSEL_BIT      6
`define MCW_DOG_KICK_BIT      0
`define MCW_DOG_FLAG_BIT      6
`define MCW_DOG_EN_BIT        7

`define MCW_RST_CONFIG        8'h00
`define MCW_RST_PULLUP        8'h00
`define MCW_RST_IRQ_DELAY     4'h2
`define MCW_RST_DOG           8'h00

`define MCW_IRQ_TIMEOUT_BIT   0
`define MCW_IRQ_IDLE_BIT      1

`define MCW_CLK_HZ            40000000
`define MCW_TICK_MS           1
`define MCW_TICK_CYC          ((`MCW_CLK_HZ / 1000) * `MCW_TICK_MS)
`define MCW_DOG_TIMEOUT_MS    32
`define MCW_IDLE_WAKE_US      400
`define MCW_IDLE_WAKE_CYC     ((`MCW_CLK_HZ / 1000000) * `MCW_IDLE_WAKE_US)

`endif

/* File: src/mcw_tick_div.v */
/*
 * Divider producing a one-cycle enable pulse every PERIOD clocks.
 * Assumes a free-running clock; run_i low holds the count at zero.
 */
`include "mcw_defines.vh"
module mcw_tick_div #(
    parameter PERIOD = `MCW_TICK_CYC
) (
    input  wire clk_i,
    input  wire rst_b_i,
    input  wire run_i,
    output reg  tick_o
);
    reg [31:0] cnt_r;

    always @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cnt_r  <= 32'h0;
            tick_o <= 1'b0;
        end else if (!run_i) begin
            cnt_r  <= 32'h0;
            tick_o <= 1'b0;
        end else if (cnt_r == PERIOD - 1) begin
            cnt_r  <= 32'h0;
            tick_o <= 1'b1;
        end else begin
            cnt_r  <= cnt_r + 32'h1;
            tick_o <= 1'b0;
        end
    end
endmodule

/* File: src/mcw_top.v */
/*
 * MCU configuration upper bits, port pull-ups, port 2 interrupt delay,
 * watchdog with 1 ms timebase, sticky event status and interrupt.
 * Assumes register strobes and core status on clk_i; pins and
 * start-of-frame/USB reset come asynchronously and are synchronised.
 */
`include "mcw_defines.vh"
module mcw_top #(
    parameter TICK_CYC = `MCW_TICK_CYC,
    parameter WAKE_CYC = `MCW_IDLE_WAKE_CYC
) (
    input  wire                   clk_i,
    input  wire                   rst_b_i,
    input  wire [`MCW_ADDR_W-1:0] addr_i,
    input  wire [7:0]             wdata_i,
    input  wire                   wr_i,
    input  wire                   rd_i,
    output reg  [7:0]             rdata_o,
    input  wire                   sof_i,
    input  wire                   usb_reset_i,
    input  wire                   idle_request_i,
    input  wire                   port3_bit3_pin_i,
    input  wire [7:0]             port2_pins_i,
    output wire                   ext_irq_line_b_o,
    output wire                   idle_clear_o,
    output wire                   overcurrent_detect_enable_o,
    output wire [31:0]            pullup_en_o,
    output wire [3:0]             port2_irq_delay_o,
    output reg                    mcu_reset_o,
    output wire                   irq_o
);
    reg  [1:0] sof_s_r;
    reg  [1:0] usbrst_s_r;
    reg  [1:0] p33_s_r;
    reg  [7:0] p2_s0_r;
    reg  [7:0] p2_s1_r;
    wire       sof_q    = sof_s_r[1];
    wire       usbrst_q = usbrst_s_r[1];

    always @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            sof_s_r    <= 2'h0;
            usbrst_s_r <= 2'h0;
            p33_s_r    <= 2'h0;
            p2_s0_r    <= 8'h00;
            p2_s1_r    <= 8'h00;
        end else begin
            sof_s_r    <= {sof_s_r[0], sof_i};
            usbrst_s_r <= {usbrst_s_r[0], usb_reset_i};
            p33_s_r    <= {p33_s_r[0], port3_bit3_pin_i};
            p2_s0_r    <= port2_pins_i;
            p2_s1_r    <= p2_s0_r;
        end
    end

    // Register write strobes and watchdog register read/write access
    wire wr_cfg   = wr_i && (addr_i == `MCW_OFS_CONFIG);
    wire wr_dly   = wr_i && (addr_i == `MCW_OFS_IRQ_DELAY);
    wire wr_dog   = wr_i && (addr_i == `MCW_OFS_DOG);
    wire wr_st    = wr_i && (addr_i == `MCW_OFS_IRQ_STATUS);
    wire wr_msk   = wr_i && (addr_i == `MCW_OFS_IRQ_MASK);
    wire dog_acc  = (wr_i || rd_i) && (addr_i == `MCW_OFS_DOG);
    wire kick     = wr_dog && wdata_i[`MCW_DOG_KICK_BIT];

    reg        ovc_en_r;
    reg        xsel_r;
    reg  [3:0] delay_r;
    reg        dog_en_r;
    reg        dog_flag_r;
    reg  [4:0] dog_cnt_r;
    reg        sof_seen_r;
    reg  [1:0] irq_st_r;
    reg  [1:0] irq_msk_r;
    reg  [7:0] pull_r [0:3];

    assign overcurrent_detect_enable_o = ovc_en_r;
    assign port2_irq_delay_o           = delay_r;
    assign ext_irq_line_b_o = xsel_r ? (|p2_s1_r) : p33_s_r[1];

    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1) begin : g_pull
            wire wr_p = wr_i && (addr_i == `MCW_OFS_PULLUP0 + g);
            always @(posedge clk_i or negedge rst_b_i) begin
                if (!rst_b_i)
                    pull_r[g] <= `MCW_RST_PULLUP;
                else if (usbrst_q)
                    pull_r[g] <= `MCW_RST_PULLUP;
                else if (wr_p)
                    pull_r[g] <= wdata_i;
            end
            assign pullup_en_o[g*8 +: 8] = pull_r[g];
        end
    endgenerate

    always @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            ovc_en_r <= 1'b0;
            xsel_r   <= 1'b0;
            delay_r  <= `MCW_RST_IRQ_DELAY;
        end else if (usbrst_q) begin
            ovc_en_r <= 1'b0;
            xsel_r   <= 1'b0;
            delay_r  <= `MCW_RST_IRQ_DELAY;
        end else begin
            if (wr_cfg) begin
                ovc_en_r <= wdata_i[`MCW_CFG_OVC_BIT];
                xsel_r   <= wdata_i[`MCW_CFG_XSEL_BIT];
            end
            if (wr_dly)
                delay_r <= wdata_i[3:0];
        end
    end

    // Watchdog timebase runs only when the dog may count
    wire dog_run = dog_en_r && sof_seen_r && !idle_request_i;
    wire tick;
    mcw_tick_div #(
        .PERIOD (TICK_CYC)
    ) u_tick (
        .clk_i   (clk_i),
        .rst_b_i (rst_b_i),
        .run_i   (dog_run && !dog_acc),
        .tick_o  (tick)
    );

    wire timeout = dog_run && tick && !dog_acc && (dog_cnt_r == 5'h1F);

    always @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            dog_en_r    <= 1'b0;
            dog_flag_r  <= 1'b0;
            dog_cnt_r   <= 5'h00;
            sof_seen_r  <= 1'b0;
            mcu_reset_o <= 1'b0;
        end else if (usbrst_q) begin
            dog_en_r    <= 1'b0;
            dog_flag_r  <= 1'b0;
            dog_cnt_r   <= 5'h00;
            sof_seen_r  <= 1'b0;
            mcu_reset_o <= 1'b0;
        end else begin
            mcu_reset_o <= timeout;
            if (sof_q)
                sof_seen_r <= 1'b1;
            if (wr_dog && wdata_i[`MCW_DOG_EN_BIT])
                dog_en_r <= 1'b1;
            if (timeout)
                dog_flag_r <= 1'b1;
            else if (wr_dog && wdata_i[`MCW_DOG_FLAG_BIT])
                dog_flag_r <= 1'b0;
            if (dog_acc || timeout || !dog_en_r)
                dog_cnt_r <= 5'h00;
            else if (dog_run && tick)
                dog_cnt_r <= dog_cnt_r + 5'h01;
        end
    end

    // Idle wake: line B held for the wake time clears idle
    reg [31:0] wake_cnt_r;
    reg        idle_clr_r;
    always @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            wake_cnt_r <= 32'h0;
            idle_clr_r <= 1'b0;
        end else if (!(idle_request_i && ext_irq_line_b_o)) begin
            wake_cnt_r <= 32'h0;
            idle_clr_r <= 1'b0;
        end else if (wake_cnt_r == WAKE_CYC - 1) begin
            idle_clr_r <= 1'b1;
        end else begin
            wake_cnt_r <= wake_cnt_r + 32'h1;
        end
    end
    assign idle_clear_o = idle_clr_r;

    // Sticky events; set wins over write-one-to-clear
    wire [1:0] ev = {idle_clr_r, timeout};
    always @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            irq_st_r  <= 2'h0;
            irq_msk_r <= 2'h0;
        end else begin
            irq_st_r <= (irq_st_r & ~(wr_st ? wdata_i[1:0] : 2'h0)) | ev;
            if (wr_msk)
                irq_msk_r <= wdata_i[1:0];
        end
    end
    assign irq_o = |(irq_st_r & irq_msk_r);

    // Read data one cycle after the strobe; kick bit always reads 0
    always @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i)
            rdata_o <= 8'h00;
        else if (!rd_i)
            rdata_o <= 8'h00;
        else begin
            case (addr_i)
                `MCW_OFS_CONFIG:     rdata_o <= {1'b0, xsel_r, ovc_en_r, 5'h00};
                `MCW_OFS_PULLUP0:    rdata_o <= pull_r[0];
                `MCW_OFS_PULLUP1:    rdata_o <= pull_r[1];
                `MCW_OFS_PULLUP2:    rdata_o <= pull_r[2];
                `MCW_OFS_PULLUP3:    rdata_o <= pull_r[3];
                `MCW_OFS_IRQ_DELAY:  rdata_o <= {4'h0, delay_r};
                `MCW_OFS_DOG:        rdata_o <= {dog_en_r, dog_flag_r, 6'h00};
                `MCW_OFS_IRQ_STATUS: rdata_o <= {6'h00, irq_st_r};
                `MCW_OFS_IRQ_MASK:   rdata_o <= {6'h00, irq_msk_r};
                default:             rdata_o <= 8'h00;
            endcase
        end
    end
endmodule

/* File: verif/mcw_asserts.sv */
/* Port assertions for mcw_top.
   Assumes the bind below hands on TICK_CYC. */
`include "mcw_defines.vh"
module mcw_asserts #(
    parameter int TICK_CYC = 10
) (
    input wire                   clk_i,
    input wire                   rst_b_i,
    input wire [`MCW_ADDR_W-1:0] addr_i,
    input wire [7:0]             wdata_i,
    input wire                   wr_i,
    input wire                   rd_i,
    input wire [7:0]             rdata_o,
    input wire                   usb_reset_i,
    input wire                   idle_request_i,
    input wire                   overcurrent_detect_enable_o,
    input wire [31:0]            pullup_en_o,
    input wire [3:0]             port2_irq_delay_o,
    input wire                   mcu_reset_o
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam int MIN_TO = 32 * TICK_CYC - 2;
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);
    logic [31:0] run_cnt_r;
    // Non-idle cycles since the last control access
    always @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i)
            run_cnt_r <= 32'h00000000;
        else if (((wr_i || rd_i) && addr_i == `MCW_OFS_DOG) || usb_reset_i || mcu_reset_o)
            run_cnt_r <= 32'h00000000;
        else if (!idle_request_i)
            run_cnt_r <= run_cnt_r + 32'h00000001;
    end
    property p_ovc; wr_i && addr_i == `MCW_OFS_CONFIG |=> overcurrent_detect_enable_o == $past(wdata_i[5]); endproperty
    a_ovc: assert property (p_ovc) else $error("ovc bit");
    property p_pu; wr_i && addr_i == `MCW_OFS_PULLUP0 |=> pullup_en_o[7:0] == $past(wdata_i); endproperty
    a_pu: assert property (p_pu) else $error("pullup write");
    property p_pu_hold; !wr_i && !usb_reset_i |=> $stable(pullup_en_o); endproperty
    a_pu_hold: assert property (p_pu_hold) else $error("pullup drift");
    property p_dly; wr_i && addr_i == `MCW_OFS_IRQ_DELAY |=> port2_irq_delay_o == $past(wdata_i[3:0]); endproperty
    a_dly: assert property (p_dly) else $error("delay write");
    property p_dly_ro; rd_i && addr_i == `MCW_OFS_IRQ_DELAY |=> rdata_o[7:4] == 4'h0; endproperty
    a_dly_ro: assert property (p_dly_ro) else $error("delay upper");
    property p_kick; rd_i && addr_i == `MCW_OFS_DOG |=> rdata_o[5:0] == 6'h00; endproperty
    a_kick: assert property (p_kick) else $error("kick readback");
    property p_pulse; mcu_reset_o |=> !mcu_reset_o; endproperty
    a_pulse: assert property (p_pulse) else $error("reset pulse width");
    property p_dog_min; mcu_reset_o |-> run_cnt_r >= MIN_TO; endproperty
    a_dog_min: assert property (p_dog_min) else $error("early timeout");
    c_fire: cover property (mcu_reset_o);
    c_usb: cover property (usb_reset_i);
    c_idle: cover property (idle_request_i);
endmodule
bind mcw_top mcw_asserts #(.TICK_CYC(TICK_CYC)) u_mcw_asserts (.clk_i(clk_i), .rst_b_i(rst_b_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .usb_reset_i(usb_reset_i),
    .idle_request_i(idle_request_i), .overcurrent_detect_enable_o(overcurrent_detect_enable_o),
    .pullup_en_o(pullup_en_o), .port2_irq_delay_o(port2_irq_delay_o), .mcu_reset_o(mcu_reset_o));

/* File: verif/mcw_core_model.sv */
/* Behavioural core: raises the idle request, drops it on wake or reset.
   Assumes the bench pulses go_idle_i for one cycle. */
module mcw_core_model (
    input  wire  clk_i,
    input  wire  rst_b_i,
    input  wire  go_idle_i,
    input  wire  idle_clear_i,
    input  wire  mcu_reset_i,
    output logic idle_request_o
);
    timeunit 1ns;
    timeprecision 1ps;
    always @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i)
            idle_request_o <= 1'b0;
        else if (idle_clear_i || mcu_reset_i)
            idle_request_o <= 1'b0;
        else if (go_idle_i)
            idle_request_o <= 1'b1;
    end
endmodule

/* File: verif/mcw_tb_top.sv */
/* Self-checking bench for mcw_top with short tick and wake counts.
   Assumes the checker binds itself from its own file. */
`include "mcw_defines.vh"
module mcw_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {logic [3:0] a; logic [7:0] d, m, e;} mcw_row_t;
    logic        clk_i = 1'b0, rst_b_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0, sof_i = 1'b0, usb_i = 1'b0;
    logic        p3_pin = 1'b0, go_idle = 1'b0;
    logic [3:0]  addr_i = 4'h0;
    logic [7:0]  wdata_i = 8'h00, p2_pins = 8'h00, rdat;
    wire  [7:0]  rdata_o;
    wire  [31:0] pu_o;
    wire  [3:0]  dly_o;
    wire         line_b, idle_clr, ovc_en, mcu_rst, irq_o, idle_req;
    int          num_errors = 0, check_count = 0, rst_seen = 0, n;
    mcw_row_t    rows [9] = '{'{4'h0, 8'hFF, 8'h60, 8'h60}, '{4'h0, 8'h20, 8'h60, 8'h20},
        '{4'h1, 8'hA5, 8'hFF, 8'hA5}, '{4'h2, 8'h5A, 8'hFF, 8'h5A}, '{4'h3, 8'hFF, 8'hFF, 8'hFF},
        '{4'h4, 8'h01, 8'hFF, 8'h01}, '{4'h5, 8'hFF, 8'hFF, 8'h0F}, '{4'h6, 8'h01, 8'hFF, 8'h00},
        '{4'hF, 8'hFF, 8'hFF, 8'h00}};
    mcw_top #(.TICK_CYC(10), .WAKE_CYC(8)) dut (.clk_i(clk_i), .rst_b_i(rst_b_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .sof_i(sof_i), .usb_reset_i(usb_i),
        .idle_request_i(idle_req), .port3_bit3_pin_i(p3_pin), .port2_pins_i(p2_pins), .ext_irq_line_b_o(line_b),
        .idle_clear_o(idle_clr), .overcurrent_detect_enable_o(ovc_en), .pullup_en_o(pu_o),
        .port2_irq_delay_o(dly_o), .mcu_reset_o(mcu_rst), .irq_o(irq_o));
    mcw_core_model core (.clk_i(clk_i), .rst_b_i(rst_b_i), .go_idle_i(go_idle), .idle_clear_i(idle_clr),
        .mcu_reset_i(mcu_rst), .idle_request_o(idle_req));
    initial forever #12.5 clk_i = ~clk_i;
    always @(posedge clk_i) if (mcu_rst) rst_seen <= rst_seen + 1;
    task automatic chk(string nm, logic [31:0] exp, logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic wr(logic [3:0] a, logic [7:0] d);
        @(posedge clk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask
    task automatic rd(logic [3:0] a);
        @(posedge clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        @(posedge clk_i);
        rdat = rdata_o;
    endtask
    task automatic pin(logic p3, logic [7:0] p2, logic exp);
        @(posedge clk_i);
        p3_pin <= p3;
        p2_pins <= p2;
        repeat (4) @(negedge clk_i);
        chk("line_b", exp, line_b);
    endtask
    task automatic print_verdict;
        $display("checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        repeat (30000) @(posedge clk_i);
        num_errors++;
        print_verdict();
    end
    initial begin
        repeat (5) @(posedge clk_i);
        rst_b_i <= 1'b1;
        rd(`MCW_OFS_DOG);
        chk("dog_rst", 8'h00, rdat);
        chk("dly_rst", 4'h2, dly_o);
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].d);
            rd(rows[i].a);
            chk("readback", rows[i].e, rdat & rows[i].m);
        end
        chk("pullups", 32'h01FF5AA5, pu_o);
        chk("ovc", 1'b1, ovc_en);
        pin(1'b1, 8'h00, 1'b1);
        pin(1'b0, 8'hFF, 1'b0);
        wr(`MCW_OFS_CONFIG, 8'h40);
        pin(1'b0, 8'h10, 1'b1);
        pin(1'b1, 8'h00, 1'b0);
        wr(`MCW_OFS_IRQ_MASK, 8'h01);
        wr(`MCW_OFS_DOG, 8'h80);
        repeat (400) @(posedge clk_i);
        chk("no_sof", 0, rst_seen);
        sof_i <= 1'b1;
        @(posedge clk_i);
        sof_i <= 1'b0;
        repeat (3) begin
            repeat (300) @(posedge clk_i);
            wr(`MCW_OFS_DOG, 8'h81);
        end
        chk("kicked", 0, rst_seen);
        go_idle <= 1'b1;
        @(posedge clk_i);
        go_idle <= 1'b0;
        repeat (600) @(posedge clk_i);
        chk("idle_hold", 0, rst_seen);
        p2_pins <= 8'h80;
        repeat (24) @(posedge clk_i);
        p2_pins <= 8'h00;
        n = 0;
        while (rst_seen == 0 && n < 400) begin
            @(posedge clk_i);
            n++;
        end
        chk("dog_fires", 1, rst_seen);
        chk("dog_late", 1, n > 250);
        rd(`MCW_OFS_DOG);
        chk("flag_set", 8'hC0, rdat);
        chk("irq_set", 1'b1, irq_o);
        rd(`MCW_OFS_IRQ_STATUS);
        chk("irq_status", 8'h03, rdat);
        wr(`MCW_OFS_IRQ_MASK, 8'h00);
        @(negedge clk_i);
        chk("irq_mask", 1'b0, irq_o);
        wr(`MCW_OFS_DOG, 8'h80);
        rd(`MCW_OFS_DOG);
        chk("flag_w0", 8'hC0, rdat);
        wr(`MCW_OFS_DOG, 8'hC0);
        rd(`MCW_OFS_DOG);
        chk("flag_w1", 8'h80, rdat);
        wr(`MCW_OFS_DOG, 8'h00);
        rd(`MCW_OFS_DOG);
        chk("en_w0", 8'h80, rdat);
        wr(`MCW_OFS_IRQ_MASK, 8'h01);
        wr(`MCW_OFS_IRQ_STATUS, 8'h01);
        @(negedge clk_i);
        chk("irq_clr", 1'b0, irq_o);
        usb_i <= 1'b1;
        repeat (5) @(posedge clk_i);
        usb_i <= 1'b0;
        repeat (3) @(posedge clk_i);
        rd(`MCW_OFS_DOG);
        chk("dog_usb", 8'h00, rdat);
        chk("dly_usb", 4'h2, dly_o);
        print_verdict();
    end
endmodule
